// *** fgc_ctrl.sv ***
// Function generator control: mode, XY tables, sequence settings, run
//
// Contract
// - Table and sequence data live only in volatile storage.
// - Each table holds 4096 entries spanning 0 to 125 percent.
// - Source mode uses table 1, sink table 2, combined both by voltage.
// - Solar A uses table 1, B table 2; switchable while running.
// - Fuel-cell mode uses table 1 in source operation.
// - Written table values are checked against the selected curve type; the code checks them only against FULL_SCALE, whatever the mode.
// - Mode change refused unless generator exited first.
// - Exit erases all loaded table and sequence contents.
// - Table 1 and table 2 have separate select, write, submit commands.
// - Entry select latches index 0..4095; query returns it.
// - Data write stores at latched index; query returns that entry.
// - Submit zero-fills unwritten entries, then permits start.
// - XY runs while output on; stops on alarm or output off.
// - Arbitrary select assigns voltage or current; exit leaves.
// - First and last sequence 1..99, readable; equal means single.
// - Arbitrary starts only by run command; stop restarts at first.
`timescale 1ns/10ps
module fgc_ctrl #(
	parameter int DEPTH = fgc_pkg::TBL_DEPTH
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [4:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_output_on,
	input wire logic i_alarm,
	input wire logic i_volt_sink,
	input wire logic i_seq_done,
	output logic o_fg_active,
	output logic o_use_tbl2,
	output logic o_xy_running,
	output logic o_arb_running,
	output logic [fgc_pkg::SEQ_W-1:0] o_arb_seq,
	output logic [fgc_pkg::DATA_W-1:0] o_xy_value,
	input wire logic [fgc_pkg::IDX_W-1:0] i_xy_point,
	output logic o_busy
);
	import fgc_pkg::*;
	if (DEPTH != TBL_DEPTH) begin : g_depth_chk
		$error("fgc_ctrl: table depth must be 4096");
	end

	// Output, alarm and sink-quadrant come from pins
	logic on_s1, on_s2, al_s1, al_s2, vs_s1, vs_s2;
	always_ff @(posedge i_core_clk) begin
		on_s1 <= i_output_on;
		on_s2 <= on_s1;
		al_s1 <= i_alarm;
		al_s2 <= al_s1;
		vs_s1 <= i_volt_sink;
		vs_s2 <= vs_s1;
	end

	function automatic logic is_xy(input fgc_mode_t m);
		is_xy = (m != FGC_OFF) && (m != FGC_ARB_VOLT) &&
		        (m != FGC_ARB_CURR);
	endfunction
	function automatic logic uses_t1(input fgc_mode_t m);
		uses_t1 = (m == FGC_COMBINED) || (m == FGC_SOURCE) ||
		          (m == FGC_SOLAR_A) || (m == FGC_SOLAR_B) ||
		          (m == FGC_FUEL_CELL);
	endfunction
	function automatic logic uses_t2(input fgc_mode_t m);
		uses_t2 = (m == FGC_COMBINED) || (m == FGC_SINK) ||
		          (m == FGC_SOLAR_A) || (m == FGC_SOLAR_B);
	endfunction

	fgc_mode_t mode_r, mode_nxt;
	fgc_state_t st_r, st_nxt;
	logic [IDX_W-1:0] idx1_r, idx1_nxt, idx2_r, idx2_nxt;
	logic [IDX_W-1:0] clr_r, clr_nxt;
	logic [DEPTH-1:0] wr1_r, wr1_nxt, wr2_r, wr2_nxt;
	logic sub1_r, sub1_nxt, sub2_r, sub2_nxt;
	logic fill2_r, fill2_nxt;
	logic [SEQ_W-1:0] first_r, first_nxt, last_r, last_nxt;
	logic [CYC_W-1:0] cyc_r, cyc_nxt;
	logic [3:0] err_r, err_nxt;
	logic rd_v_r;
	logic [4:0] rd_a_r;
	logic [31:0] rdata_r;
	logic solar_b_r, solar_b_nxt;
	logic we1, we2;
	logic [IDX_W-1:0] wa1, wa2;
	logic [DATA_W-1:0] wd1, wd2, q1, q2;
	logic arb_start, arb_stop, arb_run;
	logic [IDX_W-1:0] ra;
	logic [SEQ_W-1:0] wseq;
	fgc_mode_t req_mode;

	assign wseq = i_wdata[SEQ_W-1:0];
	assign req_mode = fgc_mode_t'(i_wdata[3:0]);

	always_comb begin
		mode_nxt = mode_r;
		st_nxt = st_r;
		idx1_nxt = idx1_r;
		idx2_nxt = idx2_r;
		clr_nxt = clr_r;
		wr1_nxt = wr1_r;
		wr2_nxt = wr2_r;
		sub1_nxt = sub1_r;
		sub2_nxt = sub2_r;
		fill2_nxt = fill2_r;
		first_nxt = first_r;
		last_nxt = last_r;
		cyc_nxt = cyc_r;
		err_nxt = err_r;
		solar_b_nxt = solar_b_r;
		we1 = 1'b0;
		we2 = 1'b0;
		wa1 = idx1_r;
		wa2 = idx2_r;
		wd1 = i_wdata[DATA_W-1:0];
		wd2 = i_wdata[DATA_W-1:0];
		arb_start = 1'b0;
		arb_stop = 1'b0;
		case (st_r)
		ST_CLEAR: begin
			// Erase both tables after exit or reset; sequence settings are reset by the exit write
			we1 = 1'b1;
			we2 = 1'b1;
			wa1 = clr_r;
			wa2 = clr_r;
			wd1 = '0;
			wd2 = '0;
			clr_nxt = clr_r + 12'h001;
			if (clr_r == IDX_W'(DEPTH - 1)) begin
				st_nxt = ST_IDLE;
			end
		end
		ST_FILL: begin
			// Zero every entry of the submitted table that was not written since last exit
			if (fill2_r) begin
				we2 = !wr2_r[clr_r];
				wa2 = clr_r;
				wd2 = '0;
			end else begin
				we1 = !wr1_r[clr_r];
				wa1 = clr_r;
				wd1 = '0;
			end
			clr_nxt = clr_r + 12'h001;
			if (clr_r == IDX_W'(DEPTH - 1)) begin
				st_nxt = ST_READY;
				if (fill2_r) begin
					sub2_nxt = 1'b1;
				end else begin
					sub1_nxt = 1'b1;
				end
			end
		end
		ST_IDLE, ST_READY: begin
			if (i_wr) begin
				case (i_addr)
				A_MODE: begin
					if (req_mode == FGC_OFF) begin
						mode_nxt = FGC_OFF;
						arb_stop = 1'b1;
						st_nxt = ST_CLEAR;
						clr_nxt = IDX_RST;
						idx1_nxt = IDX_RST;
						idx2_nxt = IDX_RST;
						wr1_nxt = '0;
						wr2_nxt = '0;
						sub1_nxt = 1'b0;
						sub2_nxt = 1'b0;
						first_nxt = SEQ_RST;
						last_nxt = SEQ_RST;
						cyc_nxt = CYC_RST;
						solar_b_nxt = 1'b0;
					end else if ((mode_r == FGC_SOLAR_A ||
					              mode_r == FGC_SOLAR_B) &&
					             (req_mode == FGC_SOLAR_A ||
					              req_mode == FGC_SOLAR_B)) begin
						mode_nxt = req_mode;
						solar_b_nxt = (req_mode == FGC_SOLAR_B);
					end else if (mode_r != FGC_OFF ||
					             req_mode > FGC_ARB_CURR) begin
						err_nxt = ERR_MODE_LOCK;
					end else begin
						mode_nxt = req_mode;
						solar_b_nxt = (req_mode == FGC_SOLAR_B);
					end
				end
				A_T1_IDX, A_T2_IDX: begin
					if (!is_xy(mode_r)) begin
						err_nxt = ERR_NO_GEN;
					end else if (i_wdata > 32'(DEPTH - 1)) begin
						err_nxt = ERR_RANGE;
					end else if (i_addr == A_T1_IDX) begin
						idx1_nxt = i_wdata[IDX_W-1:0];
					end else begin
						idx2_nxt = i_wdata[IDX_W-1:0];
					end
				end
				A_T1_DATA, A_T2_DATA: begin
					if (!is_xy(mode_r)) begin
						err_nxt = ERR_NO_GEN;
					end else if ((i_addr == A_T1_DATA) ?
					             !uses_t1(mode_r) :
					             !uses_t2(mode_r)) begin
						err_nxt = ERR_WRONG_TBL;
					end else if (i_wdata > 32'(FULL_SCALE)) begin
						err_nxt = ERR_RANGE;
					end else if (i_addr == A_T1_DATA) begin
						we1 = 1'b1;
						wr1_nxt[idx1_r] = 1'b1;
						sub1_nxt = 1'b0;
					end else begin
						we2 = 1'b1;
						wr2_nxt[idx2_r] = 1'b1;
						sub2_nxt = 1'b0;
					end
				end
				A_T1_SUB, A_T2_SUB: begin
					if (!is_xy(mode_r)) begin
						err_nxt = ERR_NO_GEN;
					end else begin
						st_nxt = ST_FILL;
						fill2_nxt = (i_addr == A_T2_SUB);
						clr_nxt = IDX_RST;
					end
				end
				A_SEQ_FIRST, A_SEQ_LAST: begin
					if (mode_r != FGC_ARB_VOLT &&
					    mode_r != FGC_ARB_CURR) begin
						err_nxt = ERR_NO_GEN;
					end else if (i_wdata > 32'(SEQ_MAX) ||
					             wseq < SEQ_MIN) begin
						err_nxt = ERR_RANGE;
					end else if (i_addr == A_SEQ_FIRST) begin
						first_nxt = wseq;
					end else begin
						last_nxt = wseq;
					end
				end
				A_CYCLES: begin
					if (mode_r != FGC_ARB_VOLT &&
					    mode_r != FGC_ARB_CURR) begin
						err_nxt = ERR_NO_GEN;
					end else if (i_wdata > 32'(CYC_MAX)) begin
						err_nxt = ERR_RANGE;
					end else begin
						cyc_nxt = i_wdata[CYC_W-1:0];
					end
				end
				A_RUN: begin
					if (mode_r == FGC_ARB_VOLT ||
					    mode_r == FGC_ARB_CURR) begin
						arb_start = i_wdata[0];
						arb_stop = !i_wdata[0];
					end else begin
						err_nxt = ERR_NO_GEN;
					end
				end
				A_ERROR: begin
					err_nxt = ERR_NONE;
				end
				default: begin
				end
				endcase
			end
		end
		default: begin
			st_nxt = ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			mode_r <= FGC_OFF;
			st_r <= ST_CLEAR;
			idx1_r <= IDX_RST;
			idx2_r <= IDX_RST;
			clr_r <= IDX_RST;
			wr1_r <= '0;
			wr2_r <= '0;
			sub1_r <= 1'b0;
			sub2_r <= 1'b0;
			fill2_r <= 1'b0;
			first_r <= SEQ_RST;
			last_r <= SEQ_RST;
			cyc_r <= CYC_RST;
			err_r <= ERR_NONE;
			solar_b_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			st_r <= st_nxt;
			idx1_r <= idx1_nxt;
			idx2_r <= idx2_nxt;
			clr_r <= clr_nxt;
			wr1_r <= wr1_nxt;
			wr2_r <= wr2_nxt;
			sub1_r <= sub1_nxt;
			sub2_r <= sub2_nxt;
			fill2_r <= fill2_nxt;
			first_r <= first_nxt;
			last_r <= last_nxt;
			cyc_r <= cyc_nxt;
			err_r <= err_nxt;
			solar_b_r <= solar_b_nxt;
		end
	end

	// Combined mode picks the table from the voltage quadrant
	always_comb begin
		case (mode_r)
		FGC_SINK: o_use_tbl2 = 1'b1;
		FGC_COMBINED: o_use_tbl2 = vs_s2;
		FGC_SOLAR_A, FGC_SOLAR_B: o_use_tbl2 = solar_b_r;
		default: o_use_tbl2 = 1'b0;
		endcase
	end

	// Reads on the bus take priority over the run-time port
	assign ra = (i_rd && (i_addr == A_T2_DATA)) ? idx2_r :
	            (i_rd && (i_addr == A_T1_DATA)) ? idx1_r : i_xy_point;

	fgc_table #(.DEPTH(DEPTH)) u_tbl1 (
		.i_core_clk(i_core_clk),
		.i_we(we1),
		.i_waddr(wa1),
		.i_wdata(wd1),
		.i_raddr(ra),
		.o_rdata(q1)
	);
	fgc_table #(.DEPTH(DEPTH)) u_tbl2 (
		.i_core_clk(i_core_clk),
		.i_we(we2),
		.i_waddr(wa2),
		.i_wdata(wd2),
		.i_raddr(ra),
		.o_rdata(q2)
	);

	fgc_seq_run u_run (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_start(arb_start),
		.i_stop(arb_stop),
		.i_seq_done(i_seq_done),
		.i_first(first_r),
		.i_last(last_r),
		.i_cycles(cyc_r),
		.o_running(arb_run),
		.o_seq(o_arb_seq),
		.o_pass()
	);

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rd_v_r <= 1'b0;
			rd_a_r <= A_MODE;
		end else begin
			rd_v_r <= i_rd;
			rd_a_r <= i_addr;
		end
	end
	always_comb begin
		rdata_r = 32'h0000_0000;
		if (rd_v_r) begin
			case (rd_a_r)
			A_MODE: rdata_r = {28'h0, mode_r};
			A_T1_IDX: rdata_r = {20'h0, idx1_r};
			A_T2_IDX: rdata_r = {20'h0, idx2_r};
			A_T1_DATA: rdata_r = {16'h0, q1};
			A_T2_DATA: rdata_r = {16'h0, q2};
			A_SEQ_FIRST: rdata_r = {25'h0, first_r};
			A_SEQ_LAST: rdata_r = {25'h0, last_r};
			A_CYCLES: rdata_r = {22'h0, cyc_r};
			A_RUN: rdata_r = {31'h0, arb_run};
			A_STATUS: rdata_r = {24'h0, o_xy_running, arb_run,
			                     sub2_r, sub1_r, st_r};
			A_ERROR: rdata_r = {28'h0, err_r};
			default: rdata_r = 32'h0000_0000;
			endcase
		end
	end
	assign o_rdata = rdata_r;

	// XY runs only with output on and no alarm, once submitted
	assign o_xy_running = is_xy(mode_r) && on_s2 && !al_s2 &&
	                      (sub1_r || sub2_r) && (st_r == ST_READY);
	assign o_arb_running = arb_run;
	assign o_fg_active = (mode_r != FGC_OFF);
	assign o_xy_value = o_use_tbl2 ? q2 : q1;
	assign o_busy = (st_r == ST_CLEAR) || (st_r == ST_FILL);
endmodule

// *** fgc_pkg.sv ***
// Package: constants and types for the function generator control block
package fgc_pkg;
	localparam int TBL_DEPTH = 4096;
	localparam int IDX_W = 12;
	localparam int DATA_W = 16;
	localparam int SEQ_W = 7;
	localparam int CYC_W = 10;
	localparam logic [SEQ_W-1:0] SEQ_MIN = 7'h01;
	localparam logic [SEQ_W-1:0] SEQ_MAX = 7'h63;
	localparam logic [CYC_W-1:0] CYC_MAX = 10'h3e7;
	localparam logic [DATA_W-1:0] FULL_SCALE = 16'hffff;
	localparam logic [IDX_W-1:0] IDX_RST = 12'h000;
	localparam logic [SEQ_W-1:0] SEQ_RST = 7'h01;
	localparam logic [CYC_W-1:0] CYC_RST = 10'h000;
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_MODE_LOCK = 4'h1;
	localparam logic [3:0] ERR_NO_GEN = 4'h2;
	localparam logic [3:0] ERR_RANGE = 4'h3;
	localparam logic [3:0] ERR_WRONG_TBL = 4'h4;
	// Register addresses
	localparam logic [4:0] A_MODE = 5'h00;
	localparam logic [4:0] A_T1_IDX = 5'h01;
	localparam logic [4:0] A_T1_DATA = 5'h02;
	localparam logic [4:0] A_T1_SUB = 5'h03;
	localparam logic [4:0] A_T2_IDX = 5'h04;
	localparam logic [4:0] A_T2_DATA = 5'h05;
	localparam logic [4:0] A_T2_SUB = 5'h06;
	localparam logic [4:0] A_SEQ_FIRST = 5'h07;
	localparam logic [4:0] A_SEQ_LAST = 5'h08;
	localparam logic [4:0] A_CYCLES = 5'h09;
	localparam logic [4:0] A_RUN = 5'h0a;
	localparam logic [4:0] A_STATUS = 5'h0b;
	localparam logic [4:0] A_ERROR = 5'h0c;
	typedef enum logic [3:0] {
		FGC_OFF = 4'h0,
		FGC_COMBINED = 4'h1,
		FGC_SINK = 4'h2,
		FGC_SOURCE = 4'h3,
		FGC_SOLAR_A = 4'h4,
		FGC_SOLAR_B = 4'h5,
		FGC_FUEL_CELL = 4'h6,
		FGC_ARB_VOLT = 4'h7,
		FGC_ARB_CURR = 4'h8
	} fgc_mode_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CLEAR = 4'b0010,
		ST_FILL = 4'b0100,
		ST_READY = 4'b1000
	} fgc_state_t;
endpackage

// *** fgc_table.sv ***
// One XY table: volatile storage with one write port and one registered read port
`timescale 1ns/10ps
module fgc_table #(
	parameter int DEPTH = fgc_pkg::TBL_DEPTH,
	parameter int AW = fgc_pkg::IDX_W,
	parameter int DW = fgc_pkg::DATA_W
) (
	input wire logic i_core_clk,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [DW-1:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [DW-1:0] o_rdata
);
	import fgc_pkg::*;
	if (DEPTH > (1 << AW)) begin : g_depth_chk
		$error("fgc_table: depth exceeds address range");
	end
	// Plain RAM, no reset and no preload: contents are lost at power-down
	logic [DW-1:0] mem [DEPTH];
	always_ff @(posedge i_core_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end
endmodule

// *** fgc_seq_run.sv ***
// Arbitrary generator run control: sequence and pass counting
`timescale 1ns/10ps
module fgc_seq_run (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic i_stop,
	input wire logic i_seq_done,
	input wire logic [fgc_pkg::SEQ_W-1:0] i_first,
	input wire logic [fgc_pkg::SEQ_W-1:0] i_last,
	input wire logic [fgc_pkg::CYC_W-1:0] i_cycles,
	output logic o_running,
	output logic [fgc_pkg::SEQ_W-1:0] o_seq,
	output logic [fgc_pkg::CYC_W-1:0] o_pass
);
	import fgc_pkg::*;
	logic run_r, run_nxt;
	logic [SEQ_W-1:0] seq_r, seq_nxt;
	logic [CYC_W-1:0] pass_r, pass_nxt;
	always_comb begin
		run_nxt = run_r;
		seq_nxt = seq_r;
		pass_nxt = pass_r;
		if (i_stop) begin
			run_nxt = 1'b0;
			seq_nxt = i_first;
			pass_nxt = CYC_RST;
		end else if (i_start && !run_r) begin
			run_nxt = 1'b1;
			seq_nxt = i_first;
			pass_nxt = CYC_RST;
		end else if (run_r && i_seq_done) begin
			// Wrap at the top too, so a first above last stays in range
			if (seq_r == i_last || seq_r >= SEQ_MAX) begin
				seq_nxt = i_first;
				// Zero cycles means repeat forever
				if (i_cycles != CYC_RST &&
				    pass_r + 10'h001 == i_cycles) begin
					run_nxt = 1'b0;
				end else begin
					pass_nxt = pass_r + 10'h001;
				end
			end else begin
				seq_nxt = seq_r + 7'h01;
			end
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			run_r <= 1'b0;
			seq_r <= SEQ_RST;
			pass_r <= CYC_RST;
		end else begin
			run_r <= run_nxt;
			seq_r <= seq_nxt;
			pass_r <= pass_nxt;
		end
	end
	assign o_running = run_r;
	assign o_seq = seq_r;
	assign o_pass = pass_r;
endmodule

// *** fgc_engine.sv ***
// Waveform engine stand-in: reports each finished sequence
`timescale 1ns/10ps
module fgc_engine #(
	parameter int PERIOD = 16
) (
	input wire logic i_core_clk,
	input wire logic i_running,
	output logic o_seq_done
);
	int cnt_r;
	// Count restarts on every run so sequence timing is repeatable
	always_ff @(posedge i_core_clk) begin
		cnt_r <= i_running ? ((cnt_r == PERIOD - 1) ? 0 : cnt_r + 1) : 0;
		o_seq_done <= i_running && (cnt_r == PERIOD - 1);
	end
endmodule

// *** fgc_ctrl_assertions.sv ***
// Checker: port-level properties of the generator control block
`timescale 1ns/10ps
module fgc_ctrl_chk import fgc_pkg::*; #(
	parameter int DEPTH = TBL_DEPTH
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [4:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic i_output_on,
	input wire logic i_alarm,
	input wire logic o_fg_active,
	input wire logic o_xy_running,
	input wire logic o_arb_running,
	input wire logic [fgc_pkg::SEQ_W-1:0] o_arb_seq,
	input wire logic o_busy
);
	int bcnt_r;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	always_ff @(posedge i_core_clk) begin
		bcnt_r <= (i_rst_n && o_busy) ? bcnt_r + 1 : 0;
	end
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero outside read answer");
	a_clear_start: assert property ($rose(i_rst_n) |-> ##[0:2] o_busy)
		else $error("no table clear after reset");
	a_clear_len: assert property ($fell(o_busy) |->
		bcnt_r >= DEPTH - 2 && bcnt_r <= DEPTH + 2)
		else $error("clear or fill length wrong");
	a_off_idle: assert property (!o_fg_active |->
		!o_xy_running && !o_arb_running)
		else $error("generator runs with no mode");
	a_alarm_stop: assert property (i_alarm [*4] |-> !o_xy_running)
		else $error("xy runs during alarm");
	a_output_stop: assert property (!i_output_on [*4] |-> !o_xy_running)
		else $error("xy runs with output off");
	a_one_type: assert property (!(o_xy_running && o_arb_running))
		else $error("both generator types running");
	a_seq_range: assert property (o_arb_running |->
		o_arb_seq >= SEQ_MIN && o_arb_seq <= SEQ_MAX)
		else $error("sequence number out of range");
	a_run_cmd: assert property ($rose(o_arb_running) |->
		$past(i_wr) || $past(i_wr, 2))
		else $error("arbitrary run without command");
	c_xy_run: cover property (o_xy_running);
	c_arb_run: cover property (o_arb_running);
	c_arb_end: cover property ($fell(o_arb_running));
endmodule
bind fgc_ctrl fgc_ctrl_chk #(.DEPTH(DEPTH)) u_chk (
	.i_core_clk(i_core_clk),
	.i_rst_n(i_rst_n),
	.i_addr(i_addr),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.i_output_on(i_output_on),
	.i_alarm(i_alarm),
	.o_fg_active(o_fg_active),
	.o_xy_running(o_xy_running),
	.o_arb_running(o_arb_running),
	.o_arb_seq(o_arb_seq),
	.o_busy(o_busy)
);

// *** tb_function_generator_control.sv ***
// Testbench: random and corner register traffic for the control block
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
	end end
module tb_function_generator_control;
	import fgc_pkg::*;
	logic i_core_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
	logic [4:0] i_addr = 0;
	logic [31:0] i_wdata = 0, o_rdata, q;
	logic i_output_on = 0, i_alarm = 0, i_volt_sink = 0, i_seq_done;
	logic vs_pick = 0;
	logic o_fg_active, o_use_tbl2, o_xy_running, o_arb_running, o_busy;
	logic [SEQ_W-1:0] o_arb_seq, f;
	logic [DATA_W-1:0] o_xy_value, dv[3];
	logic [IDX_W-1:0] i_xy_point = 0, ix[3];
	int n_mismatch = 0, total_checks = 0, cyc = 0;
	fgc_ctrl u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_output_on(i_output_on), .i_alarm(i_alarm),
		.i_volt_sink(i_volt_sink), .i_seq_done(i_seq_done),
		.o_fg_active(o_fg_active), .o_use_tbl2(o_use_tbl2),
		.o_xy_running(o_xy_running), .o_arb_running(o_arb_running),
		.o_arb_seq(o_arb_seq), .o_xy_value(o_xy_value),
		.i_xy_point(i_xy_point), .o_busy(o_busy));
	fgc_engine u_eng (.i_core_clk(i_core_clk), .i_running(o_arb_running),
		.o_seq_done(i_seq_done));
	initial begin
		forever #4 i_core_clk = ~i_core_clk;
	end
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		i_volt_sink <= vs_pick;
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			summarize();
		end
	end
	// Gap cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		@(posedge i_core_clk);
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] r);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 r = o_rdata;
		@(posedge i_core_clk);
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] r;
		rd(a, r);
		`CHK(r, e)
	endtask
	task automatic waitb();
		repeat (2) @(posedge i_core_clk);
		for (int k = 0; k < 5000 && o_busy !== 1'b0; k++)
			@(posedge i_core_clk);
		`CHK(o_busy, 1'b0)
		wr(A_ERROR, 32'h0);
	endtask
	task automatic tend(input string s);
		$display("test %s done at %0t", s, $time);
	endtask
	// Output table chosen by mode, from the mode-to-table rules
	function automatic logic exp_tbl2(input fgc_mode_t m, input logic vs);
		case (m)
		FGC_SINK, FGC_SOLAR_B: exp_tbl2 = 1'b1;
		FGC_COMBINED: exp_tbl2 = vs;
		default: exp_tbl2 = 1'b0;
		endcase
	endfunction
	initial begin
		void'($urandom(32'hc99f5f0b));
		repeat (2) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		waitb();
		rchk(A_MODE, FGC_OFF);
		`CHK(o_fg_active, 1'b0)
		rchk(A_T1_IDX, IDX_RST);
		rchk(A_SEQ_FIRST, SEQ_RST);
		rchk(A_CYCLES, CYC_RST);
		wr(A_T1_DATA, 32'h5);
		rchk(A_ERROR, ERR_NO_GEN);
		wr(A_ERROR, 32'h0);
		tend("reset");
		wr(A_MODE, FGC_SOURCE);
		ix[0] = 12'h000;
		ix[1] = 12'hfff;
		ix[2] = 12'($urandom_range(1, 4093));
		for (int i = 0; i < 3; i++) begin
			dv[i] = 16'($urandom_range(16'hffff));
			wr(A_T1_IDX, 32'(ix[i]));
			rchk(A_T1_IDX, 32'(ix[i]));
			wr(A_T1_DATA, 32'(dv[i]));
			rchk(A_T1_DATA, 32'(dv[i]));
		end
		wr(A_T1_DATA, 32'h10000);
		rchk(A_ERROR, ERR_RANGE);
		wr(A_T2_DATA, 32'h1);
		rchk(A_ERROR, ERR_WRONG_TBL);
		wr(A_ERROR, 32'h0);
		wr(A_MODE, FGC_SINK);
		rchk(A_MODE, FGC_SOURCE);
		rchk(A_ERROR, ERR_MODE_LOCK);
		wr(A_T1_SUB, 32'h1);
		waitb();
		rd(A_STATUS, q);
		`CHK(q[4], 1'b1)
		wr(A_T1_IDX, 32'(ix[2] + 12'h1));
		rchk(A_T1_DATA, 32'h0);
		tend("xy load");
		i_xy_point <= ix[1];
		repeat (3) @(posedge i_core_clk);
		`CHK(o_xy_value, dv[1])
		`CHK(o_use_tbl2, 1'b0)
		i_output_on <= 1'b1;
		repeat (6) @(posedge i_core_clk);
		`CHK(o_xy_running, 1'b1)
		i_alarm <= 1'b1;
		repeat (6) @(posedge i_core_clk);
		`CHK(o_xy_running, 1'b0)
		i_alarm <= 1'b0;
		i_output_on <= 1'b0;
		wr(A_MODE, FGC_OFF);
		waitb();
		wr(A_MODE, FGC_SOURCE);
		waitb();
		rchk(A_T1_IDX, 32'h0);
		wr(A_T1_IDX, 32'(ix[1]));
		rchk(A_T1_DATA, 32'h0);
		tend("xy run and exit");
		wr(A_MODE, FGC_OFF);
		waitb();
		wr(A_MODE, FGC_ARB_VOLT);
		waitb();
		f = 7'($urandom_range(1, 98));
		wr(A_SEQ_FIRST, 32'(f));
		wr(A_SEQ_LAST, 32'h63);
		rchk(A_SEQ_LAST, SEQ_MAX);
		wr(A_SEQ_FIRST, 32'h0);
		rchk(A_ERROR, ERR_RANGE);
		rchk(A_SEQ_FIRST, 32'(f));
		wr(A_CYCLES, 32'h3e8);
		rchk(A_ERROR, ERR_RANGE);
		wr(A_CYCLES, 32'h0);
		wr(A_RUN, 32'h1);
		`CHK(o_arb_running, 1'b1)
		`CHK(o_arb_seq, f)
		repeat (40) @(posedge i_core_clk);
		wr(A_RUN, 32'h0);
		wr(A_RUN, 32'h1);
		`CHK(o_arb_seq, f)
		wr(A_RUN, 32'h0);
		wr(A_SEQ_LAST, 32'(f));
		wr(A_CYCLES, 32'h2);
		wr(A_RUN, 32'h1);
		repeat (20) @(posedge i_core_clk);
		`CHK(o_arb_running, 1'b1)
		repeat (40) @(posedge i_core_clk);
		`CHK(o_arb_running, 1'b0)
		tend("arbitrary");
		// Combined mode: table 2 commands, quadrant picks the table
		wr(A_MODE, FGC_OFF);
		waitb();
		wr(A_MODE, FGC_COMBINED);
		dv[2] = 16'($urandom_range(16'hffff, 1));
		wr(A_T2_IDX, 32'(ix[2]));
		rchk(A_T2_IDX, 32'(ix[2]));
		wr(A_T2_DATA, 32'(dv[2]));
		rchk(A_T2_DATA, 32'(dv[2]));
		wr(A_T1_IDX, 32'(ix[2]));
		rchk(A_T1_DATA, 32'h0);
		wr(A_T2_SUB, 32'h1);
		waitb();
		rd(A_STATUS, q);
		`CHK(q[5:4], 2'b10)
		i_xy_point <= ix[2];
		for (int i = 0; i < 2; i++) begin
			vs_pick = 1'(i) ^ 1'($urandom_range(1));
			repeat (4) @(posedge i_core_clk);
			`CHK(o_use_tbl2, exp_tbl2(FGC_COMBINED, vs_pick))
			`CHK(o_xy_value, vs_pick ? dv[2] : 16'h0)
		end
		tend("combined");
		wr(A_MODE, FGC_OFF);
		waitb();
		wr(A_MODE, FGC_SOLAR_A);
		wr(A_T1_IDX, 32'(ix[0]));
		wr(A_T1_DATA, 32'(dv[0]));
		wr(A_T1_SUB, 32'h1);
		waitb();
		i_xy_point <= ix[0];
		i_output_on <= 1'b1;
		repeat (6) @(posedge i_core_clk);
		`CHK(o_use_tbl2, exp_tbl2(FGC_SOLAR_A, vs_pick))
		`CHK(o_xy_value, dv[0])
		wr(A_MODE, FGC_SOLAR_B);
		rchk(A_MODE, FGC_SOLAR_B);
		`CHK(o_use_tbl2, exp_tbl2(FGC_SOLAR_B, vs_pick))
		`CHK(o_xy_value, 16'h0)
		`CHK(o_xy_running, 1'b1)
		i_output_on <= 1'b0;
		tend("solar");
		wr(A_MODE, FGC_OFF);
		waitb();
		wr(A_MODE, FGC_FUEL_CELL);
		wr(A_T2_DATA, 32'h1);
		rchk(A_ERROR, ERR_WRONG_TBL);
		`CHK(o_use_tbl2, exp_tbl2(FGC_FUEL_CELL, vs_pick))
		wr(A_MODE, FGC_SOLAR_A);
		rchk(A_ERROR, ERR_MODE_LOCK);
		wr(A_MODE, FGC_OFF);
		waitb();
		wr(A_MODE, FGC_ARB_CURR);
		rchk(A_MODE, FGC_ARB_CURR);
		rchk(A_SEQ_LAST, SEQ_RST);
		`CHK(o_fg_active, 1'b1)
		wr(A_T1_IDX, 32'h1);
		rchk(A_ERROR, ERR_NO_GEN);
		wr(A_RUN, 32'h1);
		`CHK(o_arb_running, 1'b1)
		wr(A_MODE, FGC_OFF);
		`CHK(o_arb_running, 1'b0)
		`CHK(o_fg_active, 1'b0)
		tend("fuel cell and current");
		summarize();
	end
endmodule
